// [scsm_pkg.sv]
// Package for the system clock select and monitor block.
// Assumes a single 250 MHz reference clock and a classic Wishbone slave port.
package scsm_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned RC_FREQ_KHZ = 8000;
    localparam int unsigned EXT_MIN_KHZ = 4000;
    localparam int unsigned EXT_MAX_KHZ = 32000;
    // Silence of two slowest external periods counts as a failure
    localparam int unsigned FAIL_TIME_NS = 2 * 1000000 / EXT_MIN_KHZ;
    localparam int unsigned FAIL_CYCLES = FAIL_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0] MON_LIMIT = 8'(FAIL_CYCLES - 1);

    // Ceilings software must respect; the hardware does not enforce them
    localparam int unsigned AHB_MAX_KHZ = 72000;
    localparam int unsigned HS_MAX_KHZ = 72000;
    localparam int unsigned LS_MAX_KHZ = 36000;
    localparam int unsigned ADV_MAX_KHZ = 144000;

    // ==========================================================
    // Prescaler codes: ratio is two to the power of the code
    localparam logic [3:0] AHB_CODE_MAX = 4'h9;
    localparam logic [3:0] APB_CODE_MAX = 4'h4;

    // ==========================================================
    // Register byte offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PRESC = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // Control fields
    localparam int unsigned CTRL_SRC_LSB = 0;
    localparam int unsigned CTRL_FAIL_IE = 2;
    localparam int unsigned CTRL_PLL_IE = 3;
    localparam int unsigned CTRL_PLL_EXT = 4;
    localparam int unsigned CTRL_X2_REQ = 5;

    // Prescaler fields
    localparam int unsigned PRESC_AHB_LSB = 0;
    localparam int unsigned PRESC_HS_LSB = 8;
    localparam int unsigned PRESC_LS_LSB = 16;

    // Status fields
    localparam int unsigned STAT_ACT_LSB = 0;
    localparam int unsigned STAT_EXT_FAIL = 2;
    localparam int unsigned STAT_PLL_FAIL = 3;
    localparam int unsigned STAT_X2 = 4;
    localparam int unsigned STAT_EXT_ALIVE = 5;
    localparam int unsigned STAT_PLL_LOCK = 6;

    // Reset values
    localparam logic [3:0] PRESC_RST = 4'h0;

    typedef enum logic [1:0] {SRC_RC, SRC_EXT, SRC_PLL} scsm_src_e;

endpackage

// [scsm_divider.sv]
// Power-of-two tick divider with a twice-rate timer tick.
// Assumes in_tick is a one-cycle pulse on clk.
`timescale 1ns/100ps

module scsm_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Input tick and ratio code
    input wire logic in_tick,
    input wire logic [3:0] code,
    // Divided ticks
    output logic tick,
    output logic tick_x2
);

    logic [8:0] cnt;
    logic [8:0] next_cnt;
    logic next_tick;
    logic next_tick_x2;
    logic [3:0] eff;
    logic [8:0] mask;
    logic [8:0] half;

    always_comb
    begin
        eff = (code > scsm_pkg::AHB_CODE_MAX) ? scsm_pkg::AHB_CODE_MAX : code;
        mask = 9'h1FF >> (4'h9 - eff);
        half = mask >> 1;
        next_cnt = in_tick ? cnt + 9'h001 : cnt;
        next_tick = in_tick && ((cnt & mask) == mask);
        // Ratio one keeps the timer at the bus rate, else twice it
        next_tick_x2 = (eff == 4'h0) ? next_tick : (in_tick && ((cnt & half) == half));
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt <= 9'h000;
            tick <= 1'b0;
            tick_x2 <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            tick <= next_tick;
            tick_x2 <= next_tick_x2;
        end
    end

endmodule // scsm_divider

// [scsm_top.sv]
// System clock select, external clock monitor and bus prescalers.
// Assumes ext_clk_pin and pll_lock_pin are asynchronous; sys_tick marks
// each system clock period and comes from logic on clk.
//
// What this block does
// - Reset selects the internal 8 MHz RC as system clock.
// - Software may pick the external 4-32 MHz clock; it is then watched.
// - External clock failure switches the system clock back to RC automatically.
// - External failure raises its own interrupt only while its enable is set; with pll_ext it also flags a PLL failure.
// - PLL input failures, including a lost external feed, are flagged and interruptible.
// - Separate prescalers make AHB, high-speed and low-speed peripheral ticks.
// - Doubled PLL timer clock only with PLL source and total division at most two.
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps

module scsm_top (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Clock sources
    input wire logic ext_clk_pin,
    input wire logic pll_lock_pin,
    input wire logic sys_tick,
    // Clock selection, domain ticks and interrupt request
    output logic [1:0] sys_src_sel,
    output logic adv_x2_sel,
    output logic ahb_tick,
    output logic hs_tick,
    output logic hs_tim_tick,
    output logic ls_tick,
    output logic ls_tim_tick,
    output logic irq_req
);

    // ==========================================================
    // Input synchronisers and external clock monitor
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic lock_s1;
    logic lock_s2;
    logic [7:0] mon_cnt;
    logic [7:0] next_mon_cnt;
    logic ext_alive;
    logic next_ext_alive;
    logic ext_edge;
    logic monitored;
    logic ext_fail_evt;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
        end
        else
        begin
            ext_s1 <= ext_clk_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            lock_s1 <= pll_lock_pin;
            lock_s2 <= lock_s1;
        end
    end

    // ==========================================================
    // Control and status state
    scsm_pkg::scsm_src_e src_req;
    scsm_pkg::scsm_src_e next_src_req;
    scsm_pkg::scsm_src_e active;
    scsm_pkg::scsm_src_e next_active;
    logic fail_ie;
    logic next_fail_ie;
    logic pll_ie;
    logic next_pll_ie;
    logic pll_ext;
    logic next_pll_ext;
    logic x2_req;
    logic next_x2_req;
    logic [3:0] ahb_code;
    logic [3:0] next_ahb_code;
    logic [3:0] hs_code;
    logic [3:0] next_hs_code;
    logic [3:0] ls_code;
    logic [3:0] next_ls_code;
    logic ext_flag;
    logic next_ext_flag;
    logic pll_flag;
    logic next_pll_flag;
    logic next_irq;
    logic next_x2;
    logic pll_ok;
    logic pll_fail_evt;
    logic wr;
    logic next_ack;
    logic [31:0] next_dat;

    always_comb
    begin
        ext_edge = ext_s2 ^ ext_s3;
        next_mon_cnt = mon_cnt;
        next_ext_alive = ext_alive;
        if (ext_edge)
        begin
            next_mon_cnt = 8'h00;
            next_ext_alive = 1'b1;
        end
        else if (mon_cnt == scsm_pkg::MON_LIMIT)
        begin
            next_ext_alive = 1'b0;
        end
        else
        begin
            next_mon_cnt = mon_cnt + 8'h01;
        end
        // Watched whenever external feeds or is asked to feed the system
        monitored = (src_req == scsm_pkg::SRC_EXT) || (active == scsm_pkg::SRC_EXT)
            || (pll_ext && ((src_req == scsm_pkg::SRC_PLL) || (active == scsm_pkg::SRC_PLL)));
        ext_fail_evt = monitored && ext_alive && !ext_edge && (mon_cnt == scsm_pkg::MON_LIMIT);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mon_cnt <= 8'h00;
            ext_alive <= 1'b0;
        end
        else
        begin
            mon_cnt <= next_mon_cnt;
            ext_alive <= next_ext_alive;
        end
    end

    always_comb
    begin
        wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        // A PLL fed from the external clock is only good while that clock runs
        pll_ok = lock_s2 && (!pll_ext || next_ext_alive);
        pll_fail_evt = ((active == scsm_pkg::SRC_PLL) && !pll_ok) || (pll_ext && ext_fail_evt);

        next_src_req = src_req;
        next_fail_ie = fail_ie;
        next_pll_ie = pll_ie;
        next_pll_ext = pll_ext;
        next_x2_req = x2_req;
        next_ahb_code = ahb_code;
        next_hs_code = hs_code;
        next_ls_code = ls_code;
        next_ext_flag = ext_flag;
        next_pll_flag = pll_flag;

        if (wr && (wb_adr_i == scsm_pkg::ADDR_CTRL) && wb_sel_i[0])
        begin
            next_src_req = (wb_dat_i[scsm_pkg::CTRL_SRC_LSB +: 2] == 2'h3) ? scsm_pkg::SRC_RC
                : scsm_pkg::scsm_src_e'(wb_dat_i[scsm_pkg::CTRL_SRC_LSB +: 2]);
            next_fail_ie = wb_dat_i[scsm_pkg::CTRL_FAIL_IE];
            next_pll_ie = wb_dat_i[scsm_pkg::CTRL_PLL_IE];
            next_pll_ext = wb_dat_i[scsm_pkg::CTRL_PLL_EXT];
            next_x2_req = wb_dat_i[scsm_pkg::CTRL_X2_REQ];
        end
        if (wr && (wb_adr_i == scsm_pkg::ADDR_PRESC))
        begin
            // Out-of-range codes clamp to the largest ratio
            if (wb_sel_i[0])
            begin
                next_ahb_code = (wb_dat_i[3:0] > scsm_pkg::AHB_CODE_MAX) ? scsm_pkg::AHB_CODE_MAX
                    : wb_dat_i[3:0];
            end
            if (wb_sel_i[1])
            begin
                next_hs_code = (wb_dat_i[11:8] > scsm_pkg::APB_CODE_MAX) ? scsm_pkg::APB_CODE_MAX
                    : wb_dat_i[11:8];
            end
            if (wb_sel_i[2])
            begin
                next_ls_code = (wb_dat_i[19:16] > scsm_pkg::APB_CODE_MAX) ? scsm_pkg::APB_CODE_MAX
                    : wb_dat_i[19:16];
            end
        end
        if (wr && (wb_adr_i == scsm_pkg::ADDR_STATUS) && wb_sel_i[0])
        begin
            next_ext_flag = ext_flag && !wb_dat_i[scsm_pkg::STAT_EXT_FAIL];
            next_pll_flag = pll_flag && !wb_dat_i[scsm_pkg::STAT_PLL_FAIL];
        end
        // A new failure beats a clear in the same cycle
        next_ext_flag = next_ext_flag || ext_fail_evt;
        next_pll_flag = next_pll_flag || pll_fail_evt;

        next_active = active;
        unique case (active)
            scsm_pkg::SRC_RC:
            begin
                if ((src_req == scsm_pkg::SRC_EXT) && ext_alive && !ext_fail_evt)
                    next_active = scsm_pkg::SRC_EXT;
                else if ((src_req == scsm_pkg::SRC_PLL) && pll_ok)
                    next_active = scsm_pkg::SRC_PLL;
            end
            scsm_pkg::SRC_EXT:
            begin
                if (ext_fail_evt || (src_req == scsm_pkg::SRC_RC))
                    next_active = scsm_pkg::SRC_RC;
                else if ((src_req == scsm_pkg::SRC_PLL) && pll_ok)
                    next_active = scsm_pkg::SRC_PLL;
            end
            scsm_pkg::SRC_PLL:
            begin
                if (!pll_ok || (src_req == scsm_pkg::SRC_RC))
                    next_active = scsm_pkg::SRC_RC;
                else if ((src_req == scsm_pkg::SRC_EXT) && ext_alive && !ext_fail_evt)
                    next_active = scsm_pkg::SRC_EXT;
            end
            default:
            begin
                next_active = scsm_pkg::SRC_RC;
            end
        endcase
        // After a fallback the request drops to RC so it cannot bounce back
        if (ext_fail_evt || pll_fail_evt)
        begin
            next_src_req = scsm_pkg::SRC_RC;
        end

        next_irq = (next_ext_flag && next_fail_ie) || (next_pll_flag && next_pll_ie);
        next_x2 = next_x2_req && (next_active == scsm_pkg::SRC_PLL)
            && ((next_ahb_code + next_hs_code) <= 4'h1);

        next_dat = 32'h0000_0000;
        unique case (wb_adr_i)
            scsm_pkg::ADDR_CTRL:
            begin
                next_dat[scsm_pkg::CTRL_SRC_LSB +: 2] = src_req;
                next_dat[scsm_pkg::CTRL_FAIL_IE] = fail_ie;
                next_dat[scsm_pkg::CTRL_PLL_IE] = pll_ie;
                next_dat[scsm_pkg::CTRL_PLL_EXT] = pll_ext;
                next_dat[scsm_pkg::CTRL_X2_REQ] = x2_req;
            end
            scsm_pkg::ADDR_PRESC:
            begin
                next_dat[scsm_pkg::PRESC_AHB_LSB +: 4] = ahb_code;
                next_dat[scsm_pkg::PRESC_HS_LSB +: 4] = hs_code;
                next_dat[scsm_pkg::PRESC_LS_LSB +: 4] = ls_code;
            end
            scsm_pkg::ADDR_STATUS:
            begin
                next_dat[scsm_pkg::STAT_ACT_LSB +: 2] = active;
                next_dat[scsm_pkg::STAT_EXT_FAIL] = ext_flag;
                next_dat[scsm_pkg::STAT_PLL_FAIL] = pll_flag;
                next_dat[scsm_pkg::STAT_X2] = adv_x2_sel;
                next_dat[scsm_pkg::STAT_EXT_ALIVE] = ext_alive;
                next_dat[scsm_pkg::STAT_PLL_LOCK] = lock_s2;
            end
            default:
            begin
                next_dat = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            src_req <= scsm_pkg::SRC_RC;
            active <= scsm_pkg::SRC_RC;
            fail_ie <= 1'b0;
            pll_ie <= 1'b0;
            pll_ext <= 1'b0;
            x2_req <= 1'b0;
            ahb_code <= scsm_pkg::PRESC_RST;
            hs_code <= scsm_pkg::PRESC_RST;
            ls_code <= scsm_pkg::PRESC_RST;
            ext_flag <= 1'b0;
            pll_flag <= 1'b0;
            irq_req <= 1'b0;
            adv_x2_sel <= 1'b0;
            sys_src_sel <= 2'h0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            src_req <= next_src_req;
            active <= next_active;
            fail_ie <= next_fail_ie;
            pll_ie <= next_pll_ie;
            pll_ext <= next_pll_ext;
            x2_req <= next_x2_req;
            ahb_code <= next_ahb_code;
            hs_code <= next_hs_code;
            ls_code <= next_ls_code;
            ext_flag <= next_ext_flag;
            pll_flag <= next_pll_flag;
            irq_req <= next_irq;
            adv_x2_sel <= next_x2;
            sys_src_sel <= next_active;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ==========================================================
    // Prescaler chain: peripheral domains divide the AHB tick
    scsm_divider u_ahb (
        .clk(clk),
        .nrst(nrst),
        .in_tick(sys_tick),
        .code(ahb_code),
        .tick(ahb_tick),
        .tick_x2()
    );

    scsm_divider u_hs (
        .clk(clk),
        .nrst(nrst),
        .in_tick(ahb_tick),
        .code(hs_code),
        .tick(hs_tick),
        .tick_x2(hs_tim_tick)
    );

    scsm_divider u_ls (
        .clk(clk),
        .nrst(nrst),
        .in_tick(ahb_tick),
        .code(ls_code),
        .tick(ls_tick),
        .tick_x2(ls_tim_tick)
    );

    // ==========================================================
    // Checks
    logic started;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            started <= 1'b0;
        else
            started <= 1'b1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_ext_lost;
        monitored && ext_alive && !ext_edge && (mon_cnt == scsm_pkg::MON_LIMIT);
    endsequence

    sequence s_back_on_rc;
        (active == scsm_pkg::SRC_RC) && (src_req == scsm_pkg::SRC_RC) && ext_flag;
    endsequence

    a_reset_on_rc: assert property (!started |-> (active == scsm_pkg::SRC_RC) && (sys_src_sel == 2'h0))
        else $error("source not RC after reset");
    a_ext_needs_clock: assert property ($rose(active == scsm_pkg::SRC_EXT) |-> $past(ext_alive))
        else $error("external selected while silent");
    a_fail_fallback: assert property (s_ext_lost ##0 (active == scsm_pkg::SRC_EXT) |=> s_back_on_rc)
        else $error("no fallback to RC on failure");
    a_fail_irq: assert property (s_ext_lost ##0 fail_ie && !wr |=> irq_req ##0 ext_flag)
        else $error("failure interrupt missing");
    a_irq_masked: assert property (!fail_ie && !pll_ie && !wr |=> !irq_req)
        else $error("interrupt while disabled");
    a_pll_loss: assert property ((active == scsm_pkg::SRC_PLL) && !pll_ok |=> (active == scsm_pkg::SRC_RC) && pll_flag)
        else $error("PLL loss not handled");
    a_ahb_ratio_one: assert property ((ahb_code == 4'h0) && sys_tick && !wr |=> ahb_tick)
        else $error("AHB tick missing at ratio one");
    a_x2_gate: assert property (adv_x2_sel |-> (active == scsm_pkg::SRC_PLL) && ((ahb_code + hs_code) <= 4'h1))
        else $error("doubled timer clock outside its conditions");
    a_timer_x1: assert property (($past(hs_code) == 4'h0) |-> (hs_tim_tick == hs_tick))
        else $error("timer tick differs at ratio one");
    a_code_range: assert property ((ahb_code <= scsm_pkg::AHB_CODE_MAX) && (ls_code <= scsm_pkg::APB_CODE_MAX))
        else $error("prescaler code out of range");
    a_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");

endmodule // scsm_top

// [scsm_ext_osc.sv]
// External fast clock source and PLL lock pin seen by the block.
// Assumes the bench sets run, half period and lock level.
`timescale 1ns/100ps

module scsm_ext_osc (
    // Control from the bench
    input wire logic run,
    input wire logic [7:0] half_ns,
    input wire logic lock_en,
    // Pins toward the block
    output logic ext_clk_pin,
    output logic pll_lock_pin
);
    // ==========================================================
    // Oscillator
    // A dead crystal freezes at its last level; no edges reach the monitor
    // One process owns the pin, so it has a single driver
    initial
    begin
        ext_clk_pin = 1'b0;
        forever
        begin
            if (run)
                #(half_ns) ext_clk_pin = ~ext_clk_pin;
            else
                #1;
        end
    end
    assign pll_lock_pin = lock_en;
endmodule // scsm_ext_osc

// [scsm_top_tb.sv]
// Self-checking bench for the clock select and monitor block.
// Assumes scsm_pkg, scsm_divider, scsm_top and scsm_ext_osc are compiled.
`timescale 1ns/100ps

module scsm_top_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic sys_tick = 1'b0;
    logic run = 1'b0;
    logic lock_en = 1'b0;
    logic [7:0] half_ns = 8'h10;
    logic [31:0] wb_dat_o;
    logic [31:0] q;
    logic wb_ack_o, ext_clk_pin, pll_lock_pin, adv_x2_sel, irq_req;
    logic [1:0] sys_src_sel;
    wire [4:0] tk;
    int n_fail = 0;
    int checks = 0;

    scsm_ext_osc u_scsm_ext_osc (.run(run), .half_ns(half_ns), .lock_en(lock_en),
        .ext_clk_pin(ext_clk_pin), .pll_lock_pin(pll_lock_pin));
    scsm_top u_scsm_top (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_pin(ext_clk_pin),
        .pll_lock_pin(pll_lock_pin), .sys_tick(sys_tick), .sys_src_sel(sys_src_sel),
        .adv_x2_sel(adv_x2_sel), .ahb_tick(tk[0]), .hs_tick(tk[1]), .hs_tim_tick(tk[2]),
        .ls_tick(tk[3]), .ls_tim_tick(tk[4]), .irq_req(irq_req));

    // ==========================================================
    // Clocks; the system clock runs at half the reference rate
    always #2 clk = ~clk;
    always @(posedge clk) sys_tick <= ~sys_tick;

    // ==========================================================
    // Shared tasks
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20)
        begin
            chk(32'h0, 32'h1);
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input logic [3:0] a);
        wb(1'b0, a, 32'h0, 4'hF);
    endtask

    task automatic wait_src(input logic [1:0] exp, input int lim);
        int n;
        n = 0;
        while (sys_src_sel !== exp && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk(32'(sys_src_sel), 32'(exp));
        if (sys_src_sel !== exp)
            report_and_stop();
    endtask

    // Skips two intervals so a divider caught mid-count is not measured
    task automatic period(input int i, input int exp);
        int n;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            @(posedge clk);
            while (tk[i] !== 1'b1 && n < 3000)
            begin
                @(posedge clk);
                n++;
            end
        end
        chk(32'(n + 1), 32'(exp));
        if (n >= 3000)
            report_and_stop();
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        chk(32'(sys_src_sel), 32'h0);
        chk(32'(irq_req), 32'h0);
        rd(scsm_pkg::ADDR_CTRL);
        chk(q, 32'h0);
        rd(scsm_pkg::ADDR_PRESC);
        chk(q, 32'h0);
        rd(4'hC);
        chk(q, 32'h0);
        // Source code 3 is not a source and must read back as RC
        wr(scsm_pkg::ADDR_CTRL, 32'h3);
        rd(scsm_pkg::ADDR_CTRL);
        chk(q, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_ext(input logic ie, input logic [7:0] half);
        half_ns <= half;
        run <= 1'b1;
        // Slowest clock needs a full half period plus the synchroniser to look alive
        cyc(80);
        wr(scsm_pkg::ADDR_CTRL, {29'h0, ie, 2'h1});
        wait_src(2'h1, 10);
        cyc(400);
        chk(32'(sys_src_sel), 32'h1);
        rd(scsm_pkg::ADDR_STATUS);
        chk(q & 32'h7F, 32'h21);
        run <= 1'b0;
        cyc(80);
        chk(32'(sys_src_sel), 32'h1);
        wait_src(2'h0, 120);
        chk(32'(irq_req), 32'(ie));
        rd(scsm_pkg::ADDR_STATUS);
        chk(q & 32'h7, 32'h4);
        wr(scsm_pkg::ADDR_CTRL, 32'h4);
        cyc(2);
        chk(32'(irq_req), 32'h1);
        wr(scsm_pkg::ADDR_STATUS, 32'h4);
        cyc(2);
        chk(32'(irq_req), 32'h0);
        $display("test external clock ie=%0d done", ie);
    endtask

    task automatic t_pll;
        run <= 1'b1;
        half_ns <= 8'h10;
        lock_en <= 1'b1;
        cyc(20);
        wr(scsm_pkg::ADDR_CTRL, 32'h2A);
        wait_src(2'h2, 10);
        cyc(3);
        chk(32'(adv_x2_sel), 32'h1);
        // Software keeps the domain ceilings; the block does not check them
        wr(scsm_pkg::ADDR_PRESC, 32'h0001_0001);
        cyc(3);
        chk(32'(adv_x2_sel), 32'h1);
        wr(scsm_pkg::ADDR_PRESC, 32'h0001_0101);
        cyc(3);
        chk(32'(adv_x2_sel), 32'h0);
        wr(scsm_pkg::ADDR_PRESC, 32'h0);
        lock_en <= 1'b0;
        wait_src(2'h0, 20);
        cyc(2);
        chk(32'(adv_x2_sel), 32'h0);
        chk(32'(irq_req), 32'h1);
        rd(scsm_pkg::ADDR_STATUS);
        chk(q & 32'hC, 32'h8);
        wr(scsm_pkg::ADDR_STATUS, 32'h8);
        lock_en <= 1'b1;
        cyc(10);
        wr(scsm_pkg::ADDR_CTRL, 32'h1A);
        wait_src(2'h2, 10);
        run <= 1'b0;
        wait_src(2'h0, 200);
        chk(32'(irq_req), 32'h1);
        // A lost external feed is watched, so it flags both failures
        rd(scsm_pkg::ADDR_STATUS);
        chk(q & 32'hC, 32'hC);
        wr(scsm_pkg::ADDR_STATUS, 32'hC);
        cyc(2);
        chk(32'(irq_req), 32'h0);
        $display("test pll done");
    endtask

    task automatic t_presc;
        for (int a = 0; a <= 9; a++)
        begin
            wr(scsm_pkg::ADDR_PRESC, 32'(a));
            period(0, 2 << a);
        end
        wr(scsm_pkg::ADDR_PRESC, 32'hF);
        period(0, 1024);
        for (int h = 0; h <= 4; h++)
        begin
            wr(scsm_pkg::ADDR_PRESC, (32'(h) << 8) | (32'(4 - h) << 16));
            period(1, 2 << h);
            period(2, (h == 0) ? 2 : (1 << h));
            period(3, 2 << (4 - h));
            period(4, (h == 4) ? 2 : (1 << (4 - h)));
        end
        wr(scsm_pkg::ADDR_PRESC, 32'h000F_0F01);
        period(1, 64);
        period(3, 64);
        wr(scsm_pkg::ADDR_PRESC, 32'h0);
        wb(1'b1, scsm_pkg::ADDR_PRESC, 32'h0003_0201, 4'h2);
        rd(scsm_pkg::ADDR_PRESC);
        chk(q, 32'h0000_0200);
        $display("test prescalers done");
    endtask

    initial
    begin
        cyc(4);
        nrst <= 1'b1;
        cyc(2);
        t_reset();
        t_ext(1'b1, 8'd125);
        t_ext(1'b0, 8'd16);
        t_pll();
        t_presc();
        report_and_stop();
    end
endmodule // scsm_top_tb
